//--- src/fau_pkg.sv
// Shared constants and types for the float add unit
package fau_pkg;
  localparam int FW = 32;
  localparam int SEL_W = 3;
  localparam int NREG = 8;
  // First-word fixed fields of the three add forms, and the zero field of the three-register second word
  localparam logic [9:0] IMM_OPC = 10'h3a2;
  localparam logic [15:0] RRR_OPC = 16'he710;
  localparam logic [6:0] RRR_MSW_ZERO = 7'h00;
  localparam logic [11:0] PAR_OPC = 12'he01;
  // Immediate split: six bits in the first word, ten in the second
  localparam int IMM_LSW_W = 6;
  localparam int IMM_MSW_POS = 6;
  localparam logic [15:0] IMM_LO_FILL = 16'h0000;
  // Selector positions in the second word; PAR_F_POS is in the first word
  localparam int SEL_A_POS = 0;
  localparam int SEL_B_POS = 3;
  localparam int SEL_C_POS = 6;
  localparam int PAR_D_POS = 11;
  localparam int PAR_A_POS = 8;
  localparam int PAR_E_MSW_POS = 14;
  localparam int PAR_F_POS = 1;
  // Float format, register reset value and add latency
  localparam logic [7:0] EXP_MAX = 8'hff;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam int ADD_LAT = 2;
  typedef enum logic [3:0] {
    FORM_NONE = 4'b0001,
    FORM_IMM = 4'b0010,
    FORM_RRR = 4'b0100,
    FORM_PAR = 4'b1000
  } fau_form_t;
  typedef struct packed {
    logic [15:0] lsw;
    logic [15:0] msw;
  } fau_insn_t;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } fau_store_t;
  typedef struct packed {
    logic [31:0] sum;
    logic uf;
    logic of;
  } fau_sum_t;
endpackage : fau_pkg

//--- src/fau_fp_adder.sv
// Combinational single-precision adder with underflow and overflow flags
`timescale 1ns/1ps
module fau_fp_adder (
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  output fau_pkg::fau_sum_t res_o
);
  // Denormals act as zero, round to nearest even, NaN/inf pass through
  logic a_big, sgn, lost;
  logic [31:0] big, sml;
  logic [7:0] d8;
  logic [23:0] mb, ms, mant;
  logic [26:0] bx, sx, sh, n, lmask;
  logic [27:0] s;
  logic [4:0] lz;
  logic signed [10:0] e;
  logic [24:0] mr;
  logic rnd;

  assign a_big = a_i[30:0] >= b_i[30:0];
  assign big = a_big ? a_i : b_i;
  assign sml = a_big ? b_i : a_i;
  assign mb = (big[30:23] == 8'h00) ? 24'h000000 : {1'b1, big[22:0]};
  assign ms = (sml[30:23] == 8'h00) ? 24'h000000 : {1'b1, sml[22:0]};
  assign d8 = (sml[30:23] == 8'h00) ? 8'h00 : big[30:23] - sml[30:23];
  assign bx = {mb, 3'h0};
  assign sx = {ms, 3'h0};
  assign lmask = (d8 > 8'h1a) ? 27'h7ffffff : ~(27'h7ffffff << d8);
  assign lost = |(sx & lmask);
  assign sh = ((d8 > 8'h1a) ? 27'h0 : (sx >> d8)) | {26'h0, lost};
  assign s = (a_i[31] == b_i[31]) ? {1'b0, bx} + {1'b0, sh} : {1'b0, bx} - {1'b0, sh};
  assign sgn = big[31];

  always_comb begin
    lz = 5'h00;
    for (int i = 0; i < 27; i++) begin
      if (s[i]) begin
        lz = 5'(26 - i);
      end
    end
  end

  always_comb begin
    res_o = '0;
    n = '0;
    e = '0;
    mant = '0;
    rnd = 1'b0;
    mr = '0;
    if (big[30:23] == fau_pkg::EXP_MAX) begin
      res_o.sum = big;
    end else if (sml[30:23] == fau_pkg::EXP_MAX) begin
      res_o.sum = sml;
    end else if (s == 28'h0000000) begin
      res_o.sum = 32'h0000_0000;
    end else begin
      if (s[27]) begin
        n = {s[27:2], s[1] | s[0]};
        e = 11'(big[30:23]) + 11'sh1;
      end else begin
        n = s[26:0] << lz;
        e = 11'(big[30:23]) - 11'(lz);
      end
      mant = n[26:3];
      rnd = n[2] & (n[1] | n[0] | mant[0]);
      mr = {1'b0, mant} + {24'h000000, rnd};
      if (mr[24]) begin
        mr = mr >> 1;
        e = e + 11'sh1;
      end
      if (e >= 11'shff) begin
        res_o.sum = {sgn, fau_pkg::EXP_MAX, 23'h0};
        res_o.of = 1'b1;
      end else if (e <= 11'sh0) begin
        res_o.sum = {sgn, 31'h0};
        res_o.uf = 1'b1;
      end else begin
        res_o.sum = {sgn, e[7:0], mr[22:0]};
      end
    end
  end
endmodule : fau_fp_adder

//--- src/fau_add_unit.sv
// Float add unit: three add forms, parallel store, latched float flags
`timescale 1ns/1ps
module fau_add_unit (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic INSN_VALID_I,
  input wire fau_pkg::fau_insn_t INSN_I,
  input wire logic [31:0] MEM_ADDR_I,
  input wire logic FLAG_CLR_I,
  input wire logic REG_WR_I,
  input wire logic [2:0] REG_WR_SEL_I,
  input wire logic [31:0] REG_WR_DATA_I,
  input wire logic [2:0] REG_RD_SEL_I,
  output logic DECODE_HIT_O,
  output logic [31:0] REG_RD_DATA_O,
  output fau_pkg::fau_store_t STORE_O,
  output logic ADD_DONE_O,
  output logic UNDERFLOW_FLAG_O,
  output logic OVERFLOW_FLAG_O
);
  logic [31:0] regs_q [fau_pkg::NREG];
  logic [31:0] op_a_q, op_b_q;
  logic [2:0] dst_q;
  logic stage_q;
  logic uf_q, of_q;
  fau_pkg::fau_store_t store_q;
  fau_pkg::fau_form_t form;
  fau_pkg::fau_sum_t sum;
  logic [15:0] lsw, msw, imm;
  logic [31:0] imm_full, op_a, op_b;
  logic [2:0] sel_a, sel_b, sel_c, par_d, par_a, par_e, par_f, dst, src1, src2;
  logic hit_imm, hit_rrr, hit_par, issue;

  assign lsw = INSN_I.lsw;
  assign msw = INSN_I.msw;
  assign hit_imm = lsw[15:6] == fau_pkg::IMM_OPC;
  assign hit_rrr = (lsw == fau_pkg::RRR_OPC) && (msw[15:9] == fau_pkg::RRR_MSW_ZERO);
  assign hit_par = lsw[15:4] == fau_pkg::PAR_OPC;
  assign form = !INSN_VALID_I ? fau_pkg::FORM_NONE :
                hit_imm ? fau_pkg::FORM_IMM :
                hit_rrr ? fau_pkg::FORM_RRR :
                hit_par ? fau_pkg::FORM_PAR : fau_pkg::FORM_NONE;
  assign issue = form != fau_pkg::FORM_NONE;
  assign DECODE_HIT_O = issue;

  // Three-bit selector fields, eight registers each
  assign sel_a = msw[fau_pkg::SEL_A_POS +: fau_pkg::SEL_W];
  assign sel_b = msw[fau_pkg::SEL_B_POS +: fau_pkg::SEL_W];
  assign sel_c = msw[fau_pkg::SEL_C_POS +: fau_pkg::SEL_W];
  assign par_d = msw[fau_pkg::PAR_D_POS +: fau_pkg::SEL_W];
  assign par_a = msw[fau_pkg::PAR_A_POS +: fau_pkg::SEL_W];
  assign par_e = {lsw[0], msw[fau_pkg::PAR_E_MSW_POS +: 2]};
  assign par_f = lsw[fau_pkg::PAR_F_POS +: fau_pkg::SEL_W];

  // Immediate straddles the two words; low half of the word forced to zero
  assign imm = {lsw[fau_pkg::IMM_LSW_W-1:0], msw[15:fau_pkg::IMM_MSW_POS]};
  assign imm_full = {imm, fau_pkg::IMM_LO_FILL};

  always_comb begin
    dst = sel_a;
    src1 = sel_b;
    src2 = sel_c;
    unique case (form)
      fau_pkg::FORM_IMM: begin
        dst = sel_a;
        src1 = sel_b;
        src2 = sel_b;
      end
      fau_pkg::FORM_RRR: begin
        dst = sel_a;
        src1 = sel_b;
        src2 = sel_c;
      end
      fau_pkg::FORM_PAR: begin
        dst = par_d;
        src1 = par_e;
        src2 = par_f;
      end
      fau_pkg::FORM_NONE: begin
        dst = sel_a;
        src1 = sel_b;
        src2 = sel_c;
      end
    endcase
  end

  assign op_a = regs_q[src1];
  assign op_b = (form == fau_pkg::FORM_IMM) ? imm_full : regs_q[src2];

  // Stage one holds operands; adder result lands in the file one edge later
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      stage_q <= 1'b0;
      op_a_q <= fau_pkg::REG_RST;
      op_b_q <= fau_pkg::REG_RST;
      dst_q <= 3'h0;
    end else begin
      stage_q <= issue;
      op_a_q <= op_a;
      op_b_q <= op_b;
      dst_q <= dst;
    end
  end

  fau_fp_adder u_adder (
    .a_i(op_a_q),
    .b_i(op_b_q),
    .res_o(sum)
  );

  // Add writeback beats a host write to the same register; the caller
  // must keep the delay slot off the destination anyway
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < fau_pkg::NREG; i++) begin
        regs_q[i] <= fau_pkg::REG_RST;
      end
    end else begin
      if (REG_WR_I) begin
        regs_q[REG_WR_SEL_I] <= REG_WR_DATA_I;
      end
      if (stage_q) begin
        regs_q[dst_q] <= sum.sum;
      end
    end
  end

  // Parallel store: one cycle, register contents read at issue
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      store_q <= '0;
    end else begin
      store_q.valid <= form == fau_pkg::FORM_PAR;
      store_q.addr <= MEM_ADDR_I;
      store_q.data <= regs_q[par_a];
    end
  end

  // Latched flags: only these two move; set wins over clear
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      uf_q <= 1'b0;
      of_q <= 1'b0;
    end else begin
      uf_q <= (stage_q & sum.uf) | (uf_q & ~FLAG_CLR_I);
      of_q <= (stage_q & sum.of) | (of_q & ~FLAG_CLR_I);
    end
  end

  assign STORE_O = store_q;
  assign ADD_DONE_O = stage_q;
  assign UNDERFLOW_FLAG_O = uf_q;
  assign OVERFLOW_FLAG_O = of_q;
  assign REG_RD_DATA_O = regs_q[REG_RD_SEL_I];

  property p_imm_widen;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      form == fau_pkg::FORM_IMM |=> op_b_q[15:0] == 16'h0000;
  endproperty
  a_imm_widen: assert property (p_imm_widen) else $error("Immediate low half not zero");

  property p_imm_decode;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      INSN_VALID_I && lsw[15:6] == 10'h3a2 |-> form == fau_pkg::FORM_IMM;
  endproperty
  a_imm_decode: assert property (p_imm_decode) else $error("Immediate form missed");

  property p_imm_sum;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      form == fau_pkg::FORM_IMM && !REG_WR_I
      |=> (op_a_q == $past(regs_q[sel_b]) && op_b_q[31:16] == $past(imm))
      ##1 regs_q[$past(sel_a, 2)] == $past(sum.sum);
  endproperty
  a_imm_sum: assert property (p_imm_sum) else $error("Immediate add wrong");

  property p_sel_range;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      form == fau_pkg::FORM_RRR |-> dst == msw[2:0] && src2 == msw[8:6];
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("Selector field wrong");

  property p_flags_hold;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !stage_q && !FLAG_CLR_I |=> uf_q == $past(uf_q) && of_q == $past(of_q);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("Flag moved without add");

  property p_flag_set;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      stage_q && sum.of |=> OVERFLOW_FLAG_O;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Overflow not latched");

  property p_latency;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      issue |=> ADD_DONE_O ##1 regs_q[$past(dst, 2)] == $past(sum.sum);
  endproperty
  a_latency: assert property (p_latency) else $error("Add latency not two cycles");

  property p_rrr_decode;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      INSN_VALID_I && lsw == 16'he710 && msw[15:9] != 7'h00 && !hit_imm && !hit_par
      |-> !issue;
  endproperty
  a_rrr_decode: assert property (p_rrr_decode) else $error("Bad three-reg word taken");

  property p_rrr_ops;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      form == fau_pkg::FORM_RRR |=> op_a_q == $past(regs_q[sel_b]) &&
        op_b_q == $past(regs_q[sel_c]);
  endproperty
  a_rrr_ops: assert property (p_rrr_ops) else $error("Three-reg operands wrong");

  property p_par_store;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      form == fau_pkg::FORM_PAR |=> STORE_O.valid && STORE_O.addr == $past(MEM_ADDR_I)
        && STORE_O.data == $past(regs_q[par_a])
        ##1 !STORE_O.valid || $past(form == fau_pkg::FORM_PAR);
  endproperty
  a_par_store: assert property (p_par_store) else $error("Parallel store wrong");

  property p_par_ops;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      form == fau_pkg::FORM_PAR |-> src1 == {lsw[0], msw[15:14]} && src2 == lsw[3:1]
        && dst == msw[13:11];
  endproperty
  a_par_ops: assert property (p_par_ops) else $error("Parallel selectors wrong");

  property p_store_once;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      STORE_O.valid |-> $past(form == fau_pkg::FORM_PAR);
  endproperty
  a_store_once: assert property (p_store_once) else $error("Spurious store");

  property p_sum_inf;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      stage_q && sum.of |-> sum.sum[30:23] == fau_pkg::EXP_MAX && sum.sum[22:0] == 23'h0
        && !sum.uf;
  endproperty
  a_sum_inf: assert property (p_sum_inf) else $error("Overflow result not infinity");

  c_imm: cover property (@(posedge REF_CLK_I) form == fau_pkg::FORM_IMM ##2 1'b1);
  c_rrr_uf: cover property (@(posedge REF_CLK_I) form == fau_pkg::FORM_RRR ##1 sum.uf);
  c_par: cover property (@(posedge REF_CLK_I) form == fau_pkg::FORM_PAR ##1 STORE_O.valid);
  c_clr_set: cover property (@(posedge REF_CLK_I) FLAG_CLR_I && stage_q && sum.of);
endmodule : fau_add_unit

//--- bench/fau_host_mem.sv
// Host-side data memory that takes the parallel store writes
`timescale 1ns/1ps
module fau_host_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire fau_pkg::fau_store_t store_i,
  input wire logic [3:0] rd_addr_i,
  output logic [31:0] rd_data_o
);
  logic [31:0] mem_q [16];
  // Unwritten words read all ones, so a lost store never looks like data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= 32'hffff_ffff;
      end
    end else if (store_i.valid) begin
      mem_q[store_i.addr[3:0]] <= store_i.data;
    end
  end
  assign rd_data_o = mem_q[rd_addr_i];
endmodule : fau_host_mem

//--- bench/fau_add_unit_tb.sv
// Self-checking bench for the float add unit
`timescale 1ns/1ps
module fau_add_unit_tb;
  typedef struct packed {
    logic [15:0] lsw;
    logic [15:0] msw;
    logic [2:0] dst;
    logic [31:0] sum;
    logic uf;
    logic of;
    logic par;
    logic [2:0] ssel;
  } fau_tb_row_t;
  localparam logic [31:0] pat [8] = '{32'h3f80_0000, 32'h4000_0000, 32'hbfc0_0000,
    32'h7f00_0000, 32'h0080_0000, 32'h80c0_0000, 32'h4040_0000, 32'h3f00_0000};
  localparam fau_tb_row_t rows [8] = '{
    '{16'he88f, 16'hf00e, 3'h6, 32'h4060_0000, 1'b0, 1'b0, 1'b0, 3'h0},
    '{16'he8b0, 16'h0007, 3'h7, 32'hbf80_0000, 1'b0, 1'b0, 1'b0, 3'h0},
    '{16'he710, 16'h00d8, 3'h0, 32'h7f80_0000, 1'b0, 1'b1, 1'b0, 3'h0},
    '{16'he710, 16'h0161, 3'h1, 32'h8000_0000, 1'b1, 1'b0, 1'b0, 3'h0},
    '{16'he710, 16'h01f2, 3'h2, 32'h4060_0000, 1'b0, 1'b0, 1'b0, 3'h0},
    '{16'he01c, 16'h9f00, 3'h3, 32'h3fc0_0000, 1'b0, 1'b0, 1'b1, 3'h7},
    '{16'he011, 16'he100, 3'h4, 32'h3fc0_0000, 1'b0, 1'b0, 1'b1, 3'h1},
    '{16'he88f, 16'hf015, 3'h5, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 3'h0}};
  logic clk, rst, insn_valid, flag_clr, reg_wr, decode_hit, add_done, uf_flag, of_flag;
  logic [2:0] reg_wr_sel, reg_rd_sel;
  logic [31:0] mem_addr, reg_wr_data, reg_rd_data, mem_rd;
  fau_pkg::fau_insn_t insn;
  fau_pkg::fau_store_t store;
  int n_errors = 0;
  int checks_done = 0;
  fau_tb_row_t r;
  fau_add_unit u_fau_add_unit (.REF_CLK_I(clk), .SYS_RST_I(rst), .INSN_VALID_I(insn_valid),
    .INSN_I(insn), .MEM_ADDR_I(mem_addr), .FLAG_CLR_I(flag_clr), .REG_WR_I(reg_wr),
    .REG_WR_SEL_I(reg_wr_sel), .REG_WR_DATA_I(reg_wr_data), .REG_RD_SEL_I(reg_rd_sel),
    .DECODE_HIT_O(decode_hit), .REG_RD_DATA_O(reg_rd_data), .STORE_O(store),
    .ADD_DONE_O(add_done), .UNDERFLOW_FLAG_O(uf_flag), .OVERFLOW_FLAG_O(of_flag));
  fau_host_mem u_fau_host_mem (.clk_i(clk), .rst_i(rst), .store_i(store),
    .rd_addr_i(mem_addr[3:0]), .rd_data_o(mem_rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Fresh register image and cleared flags before each table row, the latch case and the back-to-back case
  task automatic load_regs();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_wr_sel <= 3'(i);
      reg_wr_data <= pat[i];
    end
    @(posedge clk);
    reg_wr <= 1'b0;
    flag_clr <= 1'b1;
    @(posedge clk);
    flag_clr <= 1'b0;
  endtask : load_regs
  task automatic issue(input fau_tb_row_t x, input logic [31:0] addr);
    @(posedge clk);
    insn_valid <= 1'b1;
    insn.lsw <= x.lsw;
    insn.msw <= x.msw;
    mem_addr <= addr;
    reg_rd_sel <= x.dst;
  endtask : issue
  task automatic run_row(input fau_tb_row_t x, input logic [31:0] addr);
    issue(x, addr);
    #1;
    chk(32'(decode_hit), 32'h1, "decode");
    @(posedge clk);
    insn_valid <= 1'b0;
    #1;
    chk(32'(add_done), 32'h1, "done");
    chk(32'(store.valid), 32'(x.par), "store valid");
    if (x.par) begin
      chk(store.addr, addr, "store addr");
    end
    chk(reg_rd_data, pat[x.dst], "delay slot old value");
    @(posedge clk);
    #1;
    chk(reg_rd_data, x.sum, "sum");
    chk(32'(uf_flag), 32'(x.uf), "underflow");
    chk(32'(of_flag), 32'(x.of), "overflow");
    if (x.par) begin
      chk(mem_rd, pat[x.ssel], "stored word");
    end
  endtask : run_row
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    insn_valid = 1'b0;
    insn = '0;
    mem_addr = '0;
    flag_clr = 1'b0;
    reg_wr = 1'b0;
    reg_wr_sel = '0;
    reg_wr_data = '0;
    reg_rd_sel = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      load_regs();
      run_row(rows[i], 32'h100 + 32'(i));
    end
    // Overflow must stay latched across a clean add
    load_regs();
    run_row(rows[2], 32'h0);
    r = rows[4];
    r.of = 1'b1;
    run_row(r, 32'h0);
    @(posedge clk);
    flag_clr <= 1'b1;
    @(posedge clk);
    flag_clr <= 1'b0;
    #1;
    chk(32'(of_flag), 32'h0, "flag clear");
    // Clear in the cycle the overflowing add finishes: set wins
    issue(rows[2], 32'h0);
    @(posedge clk);
    insn_valid <= 1'b0;
    flag_clr <= 1'b1;
    @(posedge clk);
    flag_clr <= 1'b0;
    #1;
    chk(32'(of_flag), 32'h1, "set beats clear");
    // Three-register form with nonzero high bits is not an add
    // Destination is r2; the sum of r6 and r3 would differ from its content
    r = rows[2];
    r.msw = 16'h02f2;
    r.dst = 3'h2;
    issue(r, 32'h0);
    #1;
    chk(32'(decode_hit), 32'h0, "bad word decode");
    @(posedge clk);
    insn_valid <= 1'b0;
    #1;
    chk(32'(add_done), 32'h0, "bad word done");
    @(posedge clk);
    #1;
    chk(reg_rd_data, 32'h4060_0000, "bad word no write");
    // Back-to-back adds on unrelated registers
    load_regs();
    issue(rows[1], 32'h0);
    issue(rows[3], 32'h0);
    @(posedge clk);
    insn_valid <= 1'b0;
    reg_rd_sel <= 3'h7;
    #1;
    chk(32'(add_done), 32'h1, "second done");
    chk(reg_rd_data, rows[1].sum, "first of pair");
    @(posedge clk);
    reg_rd_sel <= 3'h1;
    #1;
    chk(32'(uf_flag), 32'h1, "pair underflow");
    chk(reg_rd_data, rows[3].sum, "second of pair");
    // Second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      reg_rd_sel <= 3'(i);
      #1;
      chk(reg_rd_data, 32'h0, "reset reg");
    end
    chk(32'({store.valid, uf_flag, of_flag}), 32'h0, "reset flags");
    complete_run();
  end
endmodule : fau_add_unit_tb
